//--- tpd_pkg.sv
package tpd_pkg;

  // Port geometry
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned IDX_W     = 4;

  // Frequencies in kHz
  localparam int unsigned REF_W     = 24;
  localparam int unsigned FREQ_W    = 32;
  localparam int unsigned RATE_W    = 33;

  // Register indices into the storage array
  localparam logic [IDX_W-1:0] IDX_QA_CFG0 = 4'h0;
  localparam logic [IDX_W-1:0] IDX_SH_CFG0 = 4'h1;
  localparam logic [IDX_W-1:0] IDX_QA_CFG1 = 4'h2;
  localparam logic [IDX_W-1:0] IDX_QA_CFG2 = 4'h3;
  localparam logic [IDX_W-1:0] IDX_QA_FB   = 4'h4;
  localparam logic [IDX_W-1:0] IDX_QA_REF  = 4'h5;
  localparam logic [IDX_W-1:0] IDX_CH_FB   = 4'h6;
  localparam logic [IDX_W-1:0] IDX_CH_REF  = 4'h7;
  localparam logic [IDX_W-1:0] IDX_RX_DIV  = 4'h8;
  localparam logic [IDX_W-1:0] IDX_TX_DIV  = 4'h9;
  localparam logic [IDX_W-1:0] IDX_QB_CFG0 = 4'ha;
  localparam logic [IDX_W-1:0] IDX_SH_CFG1 = 4'hb;
  localparam logic [IDX_W-1:0] IDX_QB_CFG1 = 4'hc;
  localparam logic [IDX_W-1:0] IDX_QB_CFG2 = 4'hd;
  localparam logic [IDX_W-1:0] IDX_QB_FB   = 4'he;
  localparam logic [IDX_W-1:0] IDX_QB_REF  = 4'hf;

  // Port addresses, in index order
  localparam logic [ADDR_W-1:0] REG_ADDR [REG_COUNT] = '{
    10'h008, 10'h009, 10'h010, 10'h011, 10'h014, 10'h018, 10'h028, 10'h02a,
    10'h063, 10'h07c, 10'h088, 10'h089, 10'h090, 10'h091, 10'h094, 10'h098};

  // Words that belong to the second quad PLL only
  localparam logic [REG_COUNT-1:0] QB_ONLY_MASK = 16'hf800;
  localparam logic [DATA_W-1:0]    REG_RESET    = 16'h0000;

  // Field positions and widths
  localparam int unsigned DIV_ENC_W     = 3;
  localparam int unsigned NEW_TXDIV_LSB = 8;
  localparam int unsigned NEW_RXDIV_LSB = 0;
  localparam int unsigned OLD_TXDIV_LSB = 4;
  localparam int unsigned OLD_RXDIV_LSB = 0;
  localparam int unsigned QFB_W         = 8;
  localparam int unsigned QFB_LSB       = 0;
  localparam int unsigned QREF_W        = 5;
  localparam int unsigned QREF_LSB      = 7;
  localparam int unsigned CH_N2_W       = 8;
  localparam int unsigned CH_N2_LSB     = 8;
  localparam int unsigned CH_N1_BIT     = 7;
  localparam int unsigned CH_M_W        = 5;
  localparam int unsigned CH_M_LSB      = 11;

  // Encodings
  localparam logic [DIV_ENC_W-1:0] OUT_DIV_MAX_ENC = 3'h4;
  localparam logic [DIV_ENC_W-1:0] CH_DIV_MAX_ENC  = 3'h3;
  localparam int unsigned          FB_VAL_W        = 9;
  localparam int unsigned          M_VAL_W         = 6;
  localparam int unsigned          FIELD_OFFSET    = 2;
  localparam logic [4:0]           CODE_ONE_5      = 5'h10;
  localparam logic [7:0]           CODE_ONE_8      = 8'h10;
  localparam logic [QREF_W-1:0]    QREF_MAX_CODE   = 5'h02;
  localparam logic [CH_N2_W-1:0]   CH_N2_MAX_CODE  = 8'h03;
  localparam logic [CH_M_W-1:0]    CH_M_TWO_CODE   = 5'h00;
  localparam int unsigned          QFB_SET_N       = 8;
  localparam int unsigned QFB_LEGAL [QFB_SET_N] = '{16, 20, 32, 40, 64, 66, 80, 100};

  // Frequency relations
  localparam int unsigned QUAD_POST_DIV = 2;
  localparam int unsigned LINE_MULT     = 2;
  localparam int unsigned CH_N1_LOW     = 4;
  localparam int unsigned CH_N1_HIGH    = 5;
  localparam int unsigned CH_M_ONE      = 1;
  localparam int unsigned CH_M_TWO      = 2;
  localparam int unsigned QUAD_COUNT    = 2;
  localparam int unsigned DIR_COUNT     = 2;

  typedef enum logic [1:0] {
    SEL_QUAD_A  = 2'b00,
    SEL_QUAD_B  = 2'b01,
    SEL_CHANNEL = 2'b10
  } tpd_pll_sel_t;

  function automatic logic [IDX_W:0] reg_lookup(input logic [ADDR_W-1:0] addr);
    logic [IDX_W:0] res;
    res = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (addr == REG_ADDR[i]) begin
        res = {1'b1, IDX_W'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [FB_VAL_W-1:0] quad_fb_value(input logic [QFB_W-1:0] f);
    return FB_VAL_W'(f) + FB_VAL_W'(FIELD_OFFSET);
  endfunction

  function automatic logic quad_fb_legal(input logic [QFB_W-1:0] f);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < QFB_SET_N; i++) begin
      if (quad_fb_value(f) == FB_VAL_W'(QFB_LEGAL[i])) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  function automatic logic [M_VAL_W-1:0] quad_ref_value(input logic [QREF_W-1:0] f);
    return (f == CODE_ONE_5) ? M_VAL_W'(CH_M_ONE) : M_VAL_W'(f) + M_VAL_W'(FIELD_OFFSET);
  endfunction

  function automatic logic [FB_VAL_W-1:0] chan_n2_value(input logic [CH_N2_W-1:0] f);
    return (f == CODE_ONE_8) ? FB_VAL_W'(CH_M_ONE) : FB_VAL_W'(f) + FB_VAL_W'(FIELD_OFFSET);
  endfunction

endpackage

//--- tpd_quad_rate.sv
`timescale 1ns/10ps
module tpd_quad_rate
  import tpd_pkg::*;
(
  input  wire logic [REF_W-1:0]  ref_freq_khz,
  input  wire logic [QFB_W-1:0]  fb_field,
  input  wire logic [QREF_W-1:0] ref_field,
  output logic      [FREQ_W-1:0] pll_freq_khz
);

  localparam int unsigned PROD_W = REF_W + FB_VAL_W;

  logic [PROD_W-1:0] numer;
  logic [PROD_W-1:0] denom;
  logic [PROD_W-1:0] quot;

  // Output = reference * N / (M * 2)
  assign numer        = PROD_W'(ref_freq_khz) * PROD_W'(quad_fb_value(fb_field));
  assign denom        = PROD_W'(quad_ref_value(ref_field)) * PROD_W'(QUAD_POST_DIV);
  assign quot         = numer / denom;
  assign pll_freq_khz = quot[FREQ_W-1:0];

endmodule // tpd_quad_rate

//--- tpd_line_rate.sv
`timescale 1ns/10ps
module tpd_line_rate
  import tpd_pkg::*;
(
  input  wire logic [FREQ_W-1:0]    pll_freq_khz,
  input  wire logic [DIV_ENC_W-1:0] div_enc,
  output logic      [RATE_W-1:0]    line_rate_khz
);

  logic [RATE_W-1:0] doubled;

  // D is a power of two, so the encoding is the shift
  assign doubled       = RATE_W'(pll_freq_khz) * RATE_W'(LINE_MULT);
  assign line_rate_khz = doubled >> div_enc;

endmodule // tpd_line_rate

//--- tpd_divider_config.sv
`timescale 1ns/10ps
module tpd_divider_config
  import tpd_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                drp_en,
  input  wire logic                drp_we,
  input  wire logic [ADDR_W-1:0]   drp_addr,
  input  wire logic [DATA_W-1:0]   drp_di,
  output logic      [DATA_W-1:0]   drp_do,
  output logic                     drp_rdy,
  input  wire logic                older_family,
  input  wire logic [REF_W-1:0]    ref_freq_khz,
  input  wire tpd_pll_sel_t        tx_pll_select,
  input  wire tpd_pll_sel_t        rx_pll_select,
  output logic      [FREQ_W-1:0]   quad_a_freq_khz,
  output logic      [FREQ_W-1:0]   quad_b_freq_khz,
  output logic      [FREQ_W-1:0]   channel_freq_khz,
  output logic      [RATE_W-1:0]   tx_line_rate_khz,
  output logic      [RATE_W-1:0]   rx_line_rate_khz,
  output logic      [2:0]          fields_legal
);

  localparam int unsigned CH_PROD_W = REF_W + FB_VAL_W + 3;

  function automatic logic [FREQ_W-1:0] pick_pll(input tpd_pll_sel_t sel,
                                                 input logic [FREQ_W-1:0] qa,
                                                 input logic [FREQ_W-1:0] qb,
                                                 input logic [FREQ_W-1:0] ch);
    logic [FREQ_W-1:0] res;
    res = '0;
    case (sel)
      SEL_QUAD_A:  res = qa;
      SEL_QUAD_B:  res = qb;
      SEL_CHANNEL: res = ch;
      default:     res = '0;
    endcase
    return res;
  endfunction

  logic [DATA_W-1:0]    regs [REG_COUNT];
  logic [IDX_W:0]       lookup;
  logic                 hit_raw;
  logic [IDX_W-1:0]     hit_idx;
  logic                 qb_only;
  logic                 hit;
  logic                 wr_go;
  logic [DATA_W-1:0]    next_drp_do;

  // Port decode; the second quad PLL words other than IDX_QB_CFG0 vanish for the older family
  assign lookup      = reg_lookup(drp_addr);
  assign hit_raw     = lookup[IDX_W];
  assign hit_idx     = lookup[IDX_W-1:0];
  assign qb_only     = older_family && QB_ONLY_MASK[hit_idx];
  assign hit         = hit_raw && !qb_only;
  assign wr_go       = drp_en && drp_we && hit;
  assign next_drp_do = hit ? regs[hit_idx] : '0;

  // Storage words, one per mapped address
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          regs[gi] <= REG_RESET;
        end else if (wr_go && hit_idx == IDX_W'(gi)) begin
          regs[gi] <= drp_di;
        end
      end
    end
  endgenerate

  // Answer one cycle after the enable; read data is the pre-write word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drp_rdy <= 1'b0;
      drp_do  <= '0;
    end else begin
      drp_rdy <= drp_en;
      if (drp_en) begin
        drp_do <= next_drp_do;
      end
    end
  end

  // Output divider fields, placed by family
  logic [DIV_ENC_W-1:0] tx_div_enc;
  logic [DIV_ENC_W-1:0] rx_div_enc;
  logic [DIV_ENC_W-1:0] div_enc [DIR_COUNT];

  assign tx_div_enc = older_family ? regs[IDX_QB_CFG0][OLD_TXDIV_LSB +: DIV_ENC_W]
                                   : regs[IDX_TX_DIV][NEW_TXDIV_LSB +: DIV_ENC_W];
  assign rx_div_enc = older_family ? regs[IDX_QB_CFG0][OLD_RXDIV_LSB +: DIV_ENC_W]
                                   : regs[IDX_RX_DIV][NEW_RXDIV_LSB +: DIV_ENC_W];
  assign div_enc[0] = tx_div_enc;
  assign div_enc[1] = rx_div_enc;

  // Quad PLL divider fields
  logic [QFB_W-1:0]  qfb  [QUAD_COUNT];
  logic [QREF_W-1:0] qref [QUAD_COUNT];
  logic [FREQ_W-1:0] quad_freq [QUAD_COUNT];
  logic [FREQ_W-1:0] quad_b_eff;

  assign qfb[0]  = regs[IDX_QA_FB][QFB_LSB +: QFB_W];
  assign qref[0] = regs[IDX_QA_REF][QREF_LSB +: QREF_W];
  assign qfb[1]  = regs[IDX_QB_FB][QFB_LSB +: QFB_W];
  assign qref[1] = regs[IDX_QB_REF][QREF_LSB +: QREF_W];

  generate
    for (gi = 0; gi < QUAD_COUNT; gi++) begin : g_quad
      tpd_quad_rate u_quad (
        .ref_freq_khz (ref_freq_khz),
        .fb_field     (qfb[gi]),
        .ref_field    (qref[gi]),
        .pll_freq_khz (quad_freq[gi])
      );
    end
  endgenerate

  assign quad_b_eff = older_family ? '0 : quad_freq[1];

  // Channel PLL fields and output
  logic [CH_N2_W-1:0]   ch_n2_field;
  logic                 ch_n1_bit;
  logic [CH_M_W-1:0]    ch_m_field;
  logic [FB_VAL_W-1:0]  ch_n2_val;
  logic [2:0]           ch_n1_val;
  logic [1:0]           ch_m_val;
  logic [CH_PROD_W-1:0] ch_prod;
  logic [CH_PROD_W-1:0] ch_quot;
  logic [FREQ_W-1:0]    ch_freq_raw;

  assign ch_n2_field = regs[IDX_CH_FB][CH_N2_LSB +: CH_N2_W];
  assign ch_n1_bit   = regs[IDX_CH_FB][CH_N1_BIT];
  assign ch_m_field  = regs[IDX_CH_REF][CH_M_LSB +: CH_M_W];
  assign ch_n2_val   = chan_n2_value(ch_n2_field);
  assign ch_n1_val   = ch_n1_bit ? 3'(CH_N1_HIGH) : 3'(CH_N1_LOW);
  assign ch_m_val    = (ch_m_field == CH_M_TWO_CODE) ? 2'(CH_M_TWO) : 2'(CH_M_ONE);
  assign ch_prod     = CH_PROD_W'(ref_freq_khz) * CH_PROD_W'(ch_n1_val)
                       * CH_PROD_W'(ch_n2_val);
  assign ch_quot     = ch_prod / CH_PROD_W'(ch_m_val);
  assign ch_freq_raw = ch_quot[FREQ_W-1:0];

  // Line rates per direction from the selected PLL
  logic [FREQ_W-1:0] sel_freq  [DIR_COUNT];
  logic [RATE_W-1:0] line_rate [DIR_COUNT];

  assign sel_freq[0] = pick_pll(tx_pll_select, quad_freq[0], quad_b_eff, ch_freq_raw);
  assign sel_freq[1] = pick_pll(rx_pll_select, quad_freq[0], quad_b_eff, ch_freq_raw);

  generate
    for (gi = 0; gi < DIR_COUNT; gi++) begin : g_line
      tpd_line_rate u_line (
        .pll_freq_khz  (sel_freq[gi]),
        .div_enc       (div_enc[gi]),
        .line_rate_khz (line_rate[gi])
      );
    end
  endgenerate

  // Field legality flags for the configuring logic
  logic [2:0] next_fields_legal;
  logic       out_div_ok;
  logic       ch_div_ok;

  assign out_div_ok = (tx_div_enc <= OUT_DIV_MAX_ENC) && (rx_div_enc <= OUT_DIV_MAX_ENC);
  assign ch_div_ok  = (tx_div_enc <= CH_DIV_MAX_ENC) && (rx_div_enc <= CH_DIV_MAX_ENC);
  assign next_fields_legal[0] = quad_fb_legal(qfb[0]) && out_div_ok
                                && (qref[0] == CODE_ONE_5 || qref[0] <= QREF_MAX_CODE);
  assign next_fields_legal[1] = !older_family && quad_fb_legal(qfb[1]) && out_div_ok
                                && (qref[1] == CODE_ONE_5 || qref[1] <= QREF_MAX_CODE);
  assign next_fields_legal[2] = ch_div_ok
                                && (ch_n2_field == CODE_ONE_8 || ch_n2_field <= CH_N2_MAX_CODE)
                                && (ch_m_field == CODE_ONE_5 || ch_m_field == CH_M_TWO_CODE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quad_a_freq_khz  <= '0;
      quad_b_freq_khz  <= '0;
      channel_freq_khz <= '0;
      tx_line_rate_khz <= '0;
      rx_line_rate_khz <= '0;
      fields_legal     <= '0;
    end else begin
      quad_a_freq_khz  <= quad_freq[0];
      quad_b_freq_khz  <= quad_b_eff;
      channel_freq_khz <= ch_freq_raw;
      tx_line_rate_khz <= line_rate[0];
      rx_line_rate_khz <= line_rate[1];
      fields_legal     <= next_fields_legal;
    end
  end

  // Helpers for the checks below
  logic [DIV_ENC_W-1:0] di_tx_new;
  logic [DIV_ENC_W-1:0] di_rx_new;
  logic [DIV_ENC_W-1:0] di_tx_old;
  logic [FREQ_W-1:0]    qa_expect;
  logic [FREQ_W-1:0]    ch_expect_m2;

  assign di_tx_new    = drp_di[NEW_TXDIV_LSB +: DIV_ENC_W];
  assign di_rx_new    = drp_di[NEW_RXDIV_LSB +: DIV_ENC_W];
  assign di_tx_old    = drp_di[OLD_TXDIV_LSB +: DIV_ENC_W];
  assign qa_expect    = FREQ_W'((64'(ref_freq_khz) * 64'(quad_fb_value(qfb[0])))
                        / (64'(quad_ref_value(qref[0])) * 64'(QUAD_POST_DIV)));
  assign ch_expect_m2 = FREQ_W'((64'(ref_freq_khz) * 64'(CH_N1_LOW) * 64'(ch_n2_val))
                        / 64'(CH_M_TWO));

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  tx_div_new_a: assert property (
    (wr_go && drp_addr == REG_ADDR[IDX_TX_DIV] && !older_family) ##1 !older_family
      |-> tx_div_enc == $past(di_tx_new))
    else $error("TX output divider not taken from new-family field");

  rx_div_new_a: assert property (
    (wr_go && drp_addr == REG_ADDR[IDX_RX_DIV] && !older_family) ##1 !older_family
      |-> rx_div_enc == $past(di_rx_new))
    else $error("RX output divider not taken from new-family field");

  tx_div_old_a: assert property (
    (wr_go && drp_addr == REG_ADDR[IDX_QB_CFG0] && older_family) ##1 older_family
      |-> tx_div_enc == $past(di_tx_old))
    else $error("Older-family TX divider misplaced");

  qb_refused_a: assert property (
    (drp_en && older_family && hit_raw && QB_ONLY_MASK[hit_idx]) |=> drp_do == '0)
    else $error("Second quad PLL word answered in older family");

  qb_silent_a: assert property (
    older_family ##1 older_family |=> quad_b_freq_khz == '0)
    else $error("Second quad PLL rate shown in older family");

  qb_separate_a: assert property (
    (wr_go && drp_addr == REG_ADDR[IDX_QB_FB]) |=> $stable(regs[IDX_QA_FB]))
    else $error("Second quad PLL write disturbed first quad PLL");

  qa_freq_a: assert property (
    $stable(qa_expect) |=> quad_a_freq_khz == $past(qa_expect))
    else $error("Quad PLL A rate differs from reference times N over 2M");

  qa_fb_store_a: assert property (
    (wr_go && drp_addr == REG_ADDR[IDX_QA_FB])
      ##1 (drp_en && !drp_we && drp_addr == REG_ADDR[IDX_QA_FB])
      |=> drp_do == $past(drp_di, 2))
    else $error("Quad PLL A feedback word not read back");

  line_rate_a: assert property (
    (tx_pll_select == SEL_CHANNEL && !older_family)
      |=> tx_line_rate_khz == (RATE_W'($past(ch_freq_raw)) * RATE_W'(LINE_MULT))
                              >> $past(tx_div_enc))
    else $error("TX line rate differs from channel PLL times two over D");

  ch_freq_a: assert property (
    (ch_m_field == CH_M_TWO_CODE && !ch_n1_bit) |=> channel_freq_khz == $past(ch_expect_m2))
    else $error("Channel PLL rate wrong for M of two");

  ch_unity_a: assert property (
    (ch_n1_bit && ch_n2_field == CODE_ONE_8 && ch_m_field == CODE_ONE_5)
      |=> channel_freq_khz == FREQ_W'(64'($past(ref_freq_khz)) * 64'(CH_N1_HIGH)))
    else $error("Channel PLL field codes decoded wrongly");

endmodule // tpd_divider_config

//--- tpd_port_master.sv
`timescale 1ns/10ps
module tpd_port_master
  import tpd_pkg::*;
(
  input  wire logic              mclk,
  output logic                   drp_en,
  output logic                   drp_we,
  output logic      [ADDR_W-1:0] drp_addr,
  output logic      [DATA_W-1:0] drp_di,
  input  wire logic [DATA_W-1:0] drp_do,
  input  wire logic              drp_rdy
);
  int late;

  initial begin
    drp_en = 1'b0;
    drp_we = 1'b0;
    drp_addr = '0;
    drp_di = '0;
    late = 0;
  end

  // Single-cycle strobe, answer awaited for a bounded time
  task automatic access(input logic we, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int lat;
    @(posedge mclk);
    drp_en <= 1'b1;
    drp_we <= we;
    drp_addr <= a;
    drp_di <= d;
    @(posedge mclk);
    drp_en <= 1'b0;
    drp_we <= 1'b0;
    drp_addr <= ~a;
    drp_di <= ~d;
    lat = 0;
    do begin
      @(posedge mclk);
      lat++;
    end while (drp_rdy !== 1'b1 && lat < 4);
    q = drp_do;
    if (lat != 1 || drp_rdy !== 1'b1) late++;
  endtask

  // Write then read the same word on back-to-back strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
    @(posedge mclk);
    drp_en <= 1'b1;
    drp_we <= 1'b1;
    drp_addr <= a;
    drp_di <= d;
    @(posedge mclk);
    drp_we <= 1'b0;
    @(posedge mclk);
    drp_en <= 1'b0;
    drp_addr <= ~a;
    drp_di <= ~d;
    @(posedge mclk);
    q = drp_do;
    if (drp_rdy !== 1'b1) late++;
  endtask

  task automatic set_quad_a(input longint rf, input int n, input int m,
                            output logic refused);
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] x;
    logic              ok;
    longint            vco;
    ok = 1'b0;
    foreach (QFB_LEGAL[i]) if (n == QFB_LEGAL[i]) ok = 1'b1;
    vco = rf * n / m;
    refused = !ok || m < 1 || m > 4 || vco < 9800000 || vco > 16300000;
    if (!refused) begin
      access(1'b0, 10'h014, 16'h0000, q);
      access(1'b1, 10'h014, {q[15:8], 8'(n - 2)}, x);
      access(1'b0, 10'h018, 16'h0000, q);
      access(1'b1, 10'h018, {q[15:12], (m == 1) ? 5'h10 : 5'(m - 2), q[6:0]}, x);
    end
  endtask
endmodule // tpd_port_master

//--- transceiver_pll_divider_config_tb.sv
`timescale 1ns/10ps
module transceiver_pll_divider_config_tb
  import tpd_pkg::*;
;
  logic              mclk;
  logic              rst;
  logic              drp_en;
  logic              drp_we;
  logic              drp_rdy;
  logic              older_family;
  logic              refused;
  logic [ADDR_W-1:0] drp_addr;
  logic [DATA_W-1:0] drp_di;
  logic [DATA_W-1:0] drp_do;
  logic [REF_W-1:0]  ref_freq_khz;
  tpd_pll_sel_t      tx_pll_select;
  tpd_pll_sel_t      rx_pll_select;
  logic [FREQ_W-1:0] quad_a_freq_khz;
  logic [FREQ_W-1:0] quad_b_freq_khz;
  logic [FREQ_W-1:0] channel_freq_khz;
  logic [RATE_W-1:0] tx_line_rate_khz;
  logic [RATE_W-1:0] rx_line_rate_khz;
  logic [2:0]        fields_legal;
  logic [DATA_W-1:0] mem [REG_COUNT];
  logic [DATA_W-1:0] rd_word;
  logic [15:0]       lfsr;
  int                bad_count;
  int                comparisons;

  always #25 mclk = ~mclk;

  tpd_divider_config uut (.mclk(mclk), .rst(rst), .drp_en(drp_en), .drp_we(drp_we),
    .drp_addr(drp_addr), .drp_di(drp_di), .drp_do(drp_do), .drp_rdy(drp_rdy),
    .older_family(older_family), .ref_freq_khz(ref_freq_khz),
    .tx_pll_select(tx_pll_select), .rx_pll_select(rx_pll_select),
    .quad_a_freq_khz(quad_a_freq_khz), .quad_b_freq_khz(quad_b_freq_khz),
    .channel_freq_khz(channel_freq_khz), .tx_line_rate_khz(tx_line_rate_khz),
    .rx_line_rate_khz(rx_line_rate_khz), .fields_legal(fields_legal));

  tpd_port_master master (.mclk(mclk), .drp_en(drp_en), .drp_we(drp_we),
    .drp_addr(drp_addr), .drp_di(drp_di), .drp_do(drp_do), .drp_rdy(drp_rdy));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Model index of a mapped word, -1 when unmapped or refused
  function automatic int find(input logic [ADDR_W-1:0] a);
    find = -1;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (a == REG_ADDR[i] && !(older_family && QB_ONLY_MASK[i])) find = i;
    end
  endfunction

  task automatic rw(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    int                i;
    master.access(we, a, d, q);
    i = find(a);
    if (!we) check(q, (i < 0) ? 16'h0000 : mem[i]);
    else if (i >= 0) mem[i] = d;
  endtask

  task automatic rmw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                     input logic [DATA_W-1:0] v);
    int i;
    rw(1'b0, a, 16'h0000);
    i = find(a);
    rw(1'b1, a, (((i < 0) ? 16'h0000 : mem[i]) & ~m) | (v & m));
  endtask

  function automatic longint qf(input logic [15:0] fw, input logic [15:0] rf);
    longint n;
    longint m;
    n = fw[7:0] + 2;
    m = (rf[11:7] == 5'h10) ? 1 : rf[11:7] + 2;
    return longint'(ref_freq_khz) * n / (2 * m);
  endfunction

  function automatic logic ql(input logic [15:0] fw, input logic [15:0] rf);
    logic ok;
    ok = 1'b0;
    foreach (QFB_LEGAL[i]) if (fw[7:0] + 2 == QFB_LEGAL[i]) ok = 1'b1;
    return ok && (rf[11:7] == 5'h10 || rf[11:7] <= 5'h02);
  endfunction

  task automatic check_rates();
    longint     f [4];
    logic [7:0] c2;
    logic [4:0] mc;
    logic [2:0] tc;
    logic [2:0] rc;
    repeat (2) @(posedge mclk);
    #1;
    c2 = mem[IDX_CH_FB][15:8];
    mc = mem[IDX_CH_REF][15:11];
    tc = older_family ? mem[IDX_QB_CFG0][6:4] : mem[IDX_TX_DIV][10:8];
    rc = older_family ? mem[IDX_QB_CFG0][2:0] : mem[IDX_RX_DIV][2:0];
    f[0] = qf(mem[IDX_QA_FB], mem[IDX_QA_REF]);
    f[1] = older_family ? 0 : qf(mem[IDX_QB_FB], mem[IDX_QB_REF]);
    f[2] = longint'(ref_freq_khz) * (mem[IDX_CH_FB][7] ? 5 : 4)
           * ((c2 == 8'h10) ? 1 : c2 + 2) / ((mc == 5'h00) ? 2 : 1);
    f[3] = 0;
    check(quad_a_freq_khz, f[0]);
    check(quad_b_freq_khz, f[1]);
    check(channel_freq_khz, f[2]);
    check(tx_line_rate_khz, (f[tx_pll_select] * 2) >> tc);
    check(rx_line_rate_khz, (f[rx_pll_select] * 2) >> rc);
    check(fields_legal[0], ql(mem[IDX_QA_FB], mem[IDX_QA_REF]) && tc <= 4 && rc <= 4);
    check(fields_legal[1], !older_family && ql(mem[IDX_QB_FB], mem[IDX_QB_REF])
          && tc <= 4 && rc <= 4);
    check(fields_legal[2], (c2 == 8'h10 || c2 <= 8'h03) && (mc == 5'h10 || mc == 5'h00)
          && tc <= 3 && rc <= 3);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    test_done();
  end

  initial begin
    mclk = 1'b0;
    rst <= 1'b1;
    older_family <= 1'b0;
    ref_freq_khz <= 24'd156250;
    tx_pll_select <= SEL_QUAD_A;
    rx_pll_select <= SEL_QUAD_A;
    lfsr = 16'h0056;
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    check_rates();
    foreach (REG_ADDR[i]) rw(1'b0, REG_ADDR[i], 16'h0000);
    rw(1'b1, 10'h3ff, 16'hffff);
    rw(1'b0, 10'h3ff, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      foreach (REG_ADDR[i]) begin
        lfsr = lfsr_next(lfsr);
        rw(1'b1, REG_ADDR[i], lfsr);
      end
      foreach (REG_ADDR[i]) rw(1'b0, REG_ADDR[i], 16'h0000);
      lfsr = lfsr_next(lfsr);
      ref_freq_khz <= 24'd50000 + lfsr;
      tx_pll_select <= tpd_pll_sel_t'(lfsr[1:0]);
      rx_pll_select <= tpd_pll_sel_t'(lfsr[3:2]);
      check_rates();
    end
    rw(1'b0, 10'h014, 16'h0000);
    lfsr = lfsr_next(lfsr);
    master.wr_rd(10'h014, lfsr, rd_word);
    check(rd_word, lfsr);
    mem[IDX_QA_FB] = lfsr;
    ref_freq_khz <= 24'd156250;
    foreach (QFB_LEGAL[i]) begin
      master.set_quad_a(156250, QFB_LEGAL[i], i % 4 + 1, refused);
      if (!refused) begin
        mem[IDX_QA_FB][7:0] = 8'(QFB_LEGAL[i] - 2);
        mem[IDX_QA_REF][11:7] = (i % 4 == 0) ? 5'h10 : 5'(i % 4 - 1);
      end
      rmw(10'h07c, 16'h0700, 16'(i % 5) << 8);
      rmw(10'h063, 16'h0007, 16'((i + 2) % 5));
      tx_pll_select <= tpd_pll_sel_t'(i % 4);
      rx_pll_select <= tpd_pll_sel_t'((i + 1) % 4);
      check_rates();
    end
    for (int k = 0; k < 20; k++) begin
      rmw(10'h028, 16'hff80, {(k % 5 == 4) ? 8'h10 : 8'(k % 5), 1'(k / 5 % 2), 7'h00});
      rmw(10'h02a, 16'hf800, {(k < 10) ? 5'h10 : 5'h00, 11'h000});
      rmw(10'h07c, 16'h0700, 16'(k % 4) << 8);
      rmw(10'h063, 16'h0007, 16'(3 - k % 4));
      tx_pll_select <= SEL_CHANNEL;
      rx_pll_select <= SEL_CHANNEL;
      check_rates();
    end
    @(posedge mclk);
    older_family <= 1'b1;
    for (int k = 10; k < 16; k++) begin
      lfsr = lfsr_next(lfsr);
      rw(1'b1, REG_ADDR[k], lfsr);
      rw(1'b0, REG_ADDR[k], 16'h0000);
    end
    rmw(10'h088, 16'h0077, 16'h0032);
    tx_pll_select <= SEL_QUAD_B;
    rx_pll_select <= SEL_QUAD_A;
    check_rates();
    @(posedge mclk);
    rst <= 1'b1;
    older_family <= 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (mem[i]) mem[i] = 16'h0000;
    foreach (REG_ADDR[i]) rw(1'b0, REG_ADDR[i], 16'h0000);
    check_rates();
    check(master.late, 0);
    test_done();
  end
endmodule // transceiver_pll_divider_config_tb
